// file: obcl_pkg.sv
// Constants for the boot configuration loader around the word memory.
// Assumes a single 40 MHz system clock and AHB-Lite register access.
package obcl_pkg;

	// ----------------------------------------------------------------
	// Word memory layout
	// ----------------------------------------------------------------
	localparam int           OBCL_ADDR_W       = 11;
	localparam int           OBCL_WORD_W       = 32;
	localparam int           OBCL_ARRAY_WORDS  = 32;
	localparam int           OBCL_UID_W        = 64;
	localparam int           OBCL_TUNE_W       = 40;
	localparam int           OBCL_TUNE_HI_W    = 8;
	localparam logic [10:0]  OBCL_UID_ADDR0    = 11'h000;
	localparam logic [10:0]  OBCL_UID_ADDR1    = 11'h001;
	localparam logic [10:0]  OBCL_TUNE_ADDR0   = 11'h004;
	localparam logic [10:0]  OBCL_TUNE_ADDR1   = 11'h005;
	localparam logic [10:0]  OBCL_SPECIAL_ADDR = 11'h400;

	// ----------------------------------------------------------------
	// Special configuration word fields
	// ----------------------------------------------------------------
	localparam int           OBCL_OVR_EN_LSB   = 3;
	localparam logic [1:0]   OBCL_OVR_EN_ON    = 2'h1;
	localparam int           OBCL_PHASE_BIT    = 1;
	localparam int           OBCL_POL_BIT      = 0;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]   OBCL_REG_ADDR     = 8'h00;
	localparam logic [7:0]   OBCL_REG_WDATA    = 8'h04;
	localparam logic [7:0]   OBCL_REG_CTRL     = 8'h08;
	localparam logic [7:0]   OBCL_REG_RDATA    = 8'h0C;
	localparam logic [7:0]   OBCL_REG_SPECIAL  = 8'h10;
	localparam logic [7:0]   OBCL_REG_UID_LO   = 8'h14;
	localparam logic [7:0]   OBCL_REG_UID_HI   = 8'h18;
	localparam logic [7:0]   OBCL_REG_TUNE_LO  = 8'h1C;
	localparam logic [7:0]   OBCL_REG_TUNE_HI  = 8'h20;
	localparam logic [7:0]   OBCL_REG_STATUS   = 8'h24;
	localparam logic [7:0]   OBCL_REG_CFG      = 8'h28;

	// ----------------------------------------------------------------
	// Commands, status bits, reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]   OBCL_CMD_READ     = 8'h03;
	localparam logic [7:0]   OBCL_CMD_PROG     = 8'h40;
	localparam int           OBCL_ST_BOOT_DONE = 0;
	localparam int           OBCL_ST_BUSY      = 1;
	localparam int           OBCL_ST_WAKE_PEND = 2;
	localparam int           OBCL_CFG_TUNE_EN  = 0;
	localparam logic         OBCL_CFG_RESET    = 1'b1;
	localparam logic [31:0]  OBCL_ZERO_WORD    = 32'h0000_0000;

	typedef enum logic [10:0] {
		OBCL_S_IDLE  = 11'h001,
		OBCL_S_BOOT0 = 11'h002,
		OBCL_S_BOOT1 = 11'h004,
		OBCL_S_BOOT2 = 11'h008,
		OBCL_S_BOOT3 = 11'h010,
		OBCL_S_TUNE0 = 11'h020,
		OBCL_S_TUNE1 = 11'h040,
		OBCL_S_TUNE2 = 11'h080,
		OBCL_S_READ0 = 11'h100,
		OBCL_S_READ1 = 11'h200,
		OBCL_S_PROG  = 11'h400
	} obcl_state_e;

endpackage : obcl_pkg

// file: obcl_word_array.sv
// One-time-programmable word store: ordinary words plus the special word.
// Assumes por_n only at power-on; content survives the functional reset.
`timescale 1ns/1ps
module obcl_word_array
	import obcl_pkg::*;
(
	input  wire logic                   hclk,
	input  wire logic                   por_n,
	input  wire logic                   rd_en,
	input  wire logic                   wr_en,
	input  wire logic [OBCL_ADDR_W-1:0] addr,
	input  wire logic [OBCL_WORD_W-1:0] wdata,
	output logic      [OBCL_WORD_W-1:0] rdata
);

	logic [OBCL_WORD_W-1:0] mem_r [OBCL_ARRAY_WORDS];
	logic [OBCL_WORD_W-1:0] special_r;
	logic                   in_array;

	// One word per address
	assign in_array = (addr < OBCL_ADDR_W'(OBCL_ARRAY_WORDS));

	// ----------------------------------------------------------------
	// Programming: bits can only be set, never cleared
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			for (int i = 0; i < OBCL_ARRAY_WORDS; i++) begin
				mem_r[i] <= OBCL_ZERO_WORD;
			end
			special_r <= OBCL_ZERO_WORD;
		end else if (wr_en) begin
			if (addr == OBCL_SPECIAL_ADDR) begin
				special_r <= special_r | wdata;
			end else if (in_array) begin
				mem_r[addr[4:0]] <= mem_r[addr[4:0]] | wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read: one cycle latency, unmapped reads give zero
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			rdata <= OBCL_ZERO_WORD;
		end else if (rd_en) begin
			if (addr == OBCL_SPECIAL_ADDR) begin
				rdata <= special_r;
			end else if (in_array) begin
				rdata <= mem_r[addr[4:0]];
			end else begin
				rdata <= OBCL_ZERO_WORD;
			end
		end
	end

endmodule : obcl_word_array

// file: obcl_mode_select.sv
// Serial port clock mode: strap pins or special word override.
// Assumes strap pins are static and synchronous to hclk.
`timescale 1ns/1ps
module obcl_mode_select
	import obcl_pkg::*;
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   word_valid,
	input  wire logic [OBCL_WORD_W-1:0] special_word,
	input  wire logic                   strap_phase,
	input  wire logic                   strap_polarity,
	output logic                        serial_phase,
	output logic                        serial_polarity
);

	logic override;

	assign override = word_valid &&
		(special_word[OBCL_OVR_EN_LSB+:2] == OBCL_OVR_EN_ON);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_phase    <= 1'b0;
			serial_polarity <= 1'b0;
		end else if (override) begin
			serial_phase    <= special_word[OBCL_PHASE_BIT];
			serial_polarity <= special_word[OBCL_POL_BIT];
		end else begin
			serial_phase    <= strap_phase;
			serial_polarity <= strap_polarity;
		end
	end

endmodule : obcl_mode_select

// file: obcl_loader.sv
// Top of the boot configuration loader: AHB-Lite slave, load sequencer.
// Assumes one 40 MHz clock hclk, hresetn functional reset, por_n power-on.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module obcl_loader
	import obcl_pkg::*;
(
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    por_n,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	input  wire logic                    wakeup,
	input  wire logic                    strap_phase,
	input  wire logic                    strap_polarity,
	output logic                         serial_phase,
	output logic                         serial_polarity,
	output logic      [OBCL_UID_W-1:0]   unique_identifier,
	output logic      [OBCL_TUNE_W-1:0]  regulator_tune_register
);

	obcl_state_e            state_r;
	obcl_state_e            state_nxt;
	logic                   pend_r;
	logic                   pend_write_r;
	logic                   pend_hit_r;
	logic [7:0]             pend_addr_r;
	logic                   busy;
	logic                   take;
	logic                   finish;
	logic                   wr_done;
	logic                   cmd_read;
	logic                   cmd_prog;
	logic [OBCL_ADDR_W-1:0] word_addr_r;
	logic [OBCL_WORD_W-1:0] word_wdata_r;
	logic [OBCL_WORD_W-1:0] word_rdata_r;
	logic [OBCL_WORD_W-1:0] special_config_readback_r;
	logic                   boot_done_r;
	logic                   wake_pend_r;
	logic                   tune_en_r;
	logic                   arr_rd;
	logic                   arr_wr;
	logic [OBCL_ADDR_W-1:0] arr_addr;
	logic [OBCL_WORD_W-1:0] arr_rdata;
	logic [31:0]            reg_rdata;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Every transfer takes one wait state, more while the sequencer runs.
	assign busy     = (state_r != OBCL_S_IDLE);
	assign take     = hsel && htrans[1] && hready;
	assign finish   = pend_r && !hreadyout && !busy;
	assign wr_done  = finish && pend_write_r && pend_hit_r;
	assign cmd_read = wr_done && (pend_addr_r == OBCL_REG_CTRL) &&
		(hwdata[7:0] == OBCL_CMD_READ);
	assign cmd_prog = wr_done && (pend_addr_r == OBCL_REG_CTRL) &&
		(hwdata[7:0] == OBCL_CMD_PROG);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r       <= 1'b0;
			pend_write_r <= 1'b0;
			pend_hit_r   <= 1'b0;
			pend_addr_r  <= 8'h00;
			hreadyout    <= 1'b1;
		end else if (take) begin
			pend_r       <= 1'b1;
			pend_write_r <= hwrite;
			pend_hit_r   <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
			pend_addr_r  <= haddr[7:0];
			hreadyout    <= 1'b0;
		end else if (finish) begin
			pend_r       <= 1'b0;
			hreadyout    <= 1'b1;
		end
	end

	// Only OKAY is ever given
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		reg_rdata = OBCL_ZERO_WORD;
		if (pend_hit_r) begin
			case (pend_addr_r)
				OBCL_REG_ADDR:    reg_rdata = {21'h00_0000, word_addr_r};
				OBCL_REG_WDATA:   reg_rdata = word_wdata_r;
				OBCL_REG_RDATA:   reg_rdata = word_rdata_r;
				OBCL_REG_SPECIAL: reg_rdata = special_config_readback_r;
				OBCL_REG_UID_LO:  reg_rdata = unique_identifier[31:0];
				OBCL_REG_UID_HI:  reg_rdata = unique_identifier[63:32];
				OBCL_REG_TUNE_LO: reg_rdata = regulator_tune_register[31:0];
				OBCL_REG_TUNE_HI: reg_rdata = {24'h00_0000, regulator_tune_register[39:32]};
				OBCL_REG_STATUS: begin
					reg_rdata[OBCL_ST_BOOT_DONE] = boot_done_r;
					reg_rdata[OBCL_ST_BUSY]      = busy;
					reg_rdata[OBCL_ST_WAKE_PEND] = wake_pend_r;
				end
				OBCL_REG_CFG:     reg_rdata[OBCL_CFG_TUNE_EN] = tune_en_r;
				default:          reg_rdata = OBCL_ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= OBCL_ZERO_WORD;
		end else if (finish && !pend_write_r) begin
			hrdata <= reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_addr_r  <= 11'h000;
			word_wdata_r <= OBCL_ZERO_WORD;
			tune_en_r    <= OBCL_CFG_RESET;
		end else if (wr_done) begin
			case (pend_addr_r)
				OBCL_REG_ADDR:  word_addr_r  <= hwdata[OBCL_ADDR_W-1:0];
				OBCL_REG_WDATA: word_wdata_r <= hwdata;
				OBCL_REG_CFG:   tune_en_r    <= hwdata[OBCL_CFG_TUNE_EN];
				default: begin
				end
			endcase
		end
	end

	// Wakeup held until the sequencer is free; a new wakeup wins the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_pend_r <= 1'b0;
		end else if (wakeup && tune_en_r) begin
			wake_pend_r <= 1'b1;
		end else if (state_r == OBCL_S_TUNE0) begin
			wake_pend_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Load sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			OBCL_S_IDLE: begin
				// Host command first: it cannot be held, the wakeup can.
				if (cmd_read) begin
					state_nxt = OBCL_S_READ0;
				end else if (cmd_prog) begin
					state_nxt = OBCL_S_PROG;
				end else if (wake_pend_r) begin
					state_nxt = OBCL_S_TUNE0;
				end
			end
			OBCL_S_BOOT0: state_nxt = OBCL_S_BOOT1;
			OBCL_S_BOOT1: state_nxt = OBCL_S_BOOT2;
			OBCL_S_BOOT2: state_nxt = OBCL_S_BOOT3;
			OBCL_S_BOOT3: state_nxt = OBCL_S_IDLE;
			OBCL_S_TUNE0: state_nxt = OBCL_S_TUNE1;
			OBCL_S_TUNE1: state_nxt = OBCL_S_TUNE2;
			OBCL_S_TUNE2: state_nxt = OBCL_S_IDLE;
			OBCL_S_READ0: state_nxt = OBCL_S_READ1;
			OBCL_S_READ1: state_nxt = OBCL_S_IDLE;
			OBCL_S_PROG:  state_nxt = OBCL_S_IDLE;
			default:      state_nxt = OBCL_S_IDLE;
		endcase
	end

	// Reset lands in the boot copy, so it runs on every reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= OBCL_S_BOOT0;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		arr_rd   = 1'b1;
		arr_wr   = 1'b0;
		arr_addr = word_addr_r;
		case (state_r)
			OBCL_S_BOOT0: arr_addr = OBCL_UID_ADDR0;
			OBCL_S_BOOT1: arr_addr = OBCL_UID_ADDR1;
			OBCL_S_BOOT2: arr_addr = OBCL_SPECIAL_ADDR;
			OBCL_S_TUNE0: arr_addr = OBCL_TUNE_ADDR0;
			OBCL_S_TUNE1: arr_addr = OBCL_TUNE_ADDR1;
			OBCL_S_READ0: arr_addr = word_addr_r;
			OBCL_S_PROG: begin
				arr_rd = 1'b0;
				arr_wr = 1'b1;
			end
			default: arr_rd = 1'b0;
		endcase
	end

	// Each of BOOT1-3, TUNE1-2 and READ1 captures the word asked for by the state before it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unique_identifier <= {OBCL_UID_W{1'b0}};
		end else if (state_r == OBCL_S_BOOT1) begin
			unique_identifier[31:0] <= arr_rdata;
		end else if (state_r == OBCL_S_BOOT2) begin
			unique_identifier[63:32] <= arr_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			special_config_readback_r <= OBCL_ZERO_WORD;
			boot_done_r               <= 1'b0;
		end else if (state_r == OBCL_S_BOOT3) begin
			special_config_readback_r <= arr_rdata;
			boot_done_r               <= 1'b1;
		end else if (state_r == OBCL_S_PROG && word_addr_r == OBCL_SPECIAL_ADDR) begin
			// Reflect a freshly programmed special word at once
			special_config_readback_r <= special_config_readback_r | word_wdata_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			regulator_tune_register <= {OBCL_TUNE_W{1'b0}};
		end else if (state_r == OBCL_S_TUNE1) begin
			regulator_tune_register[31:0] <= arr_rdata;
		end else if (state_r == OBCL_S_TUNE2) begin
			regulator_tune_register[39:32] <= arr_rdata[OBCL_TUNE_HI_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_rdata_r <= OBCL_ZERO_WORD;
		end else if (state_r == OBCL_S_READ1) begin
			word_rdata_r <= arr_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	obcl_word_array u_array (
		.hclk  (hclk),
		.por_n (por_n),
		.rd_en (arr_rd),
		.wr_en (arr_wr),
		.addr  (arr_addr),
		.wdata (word_wdata_r),
		.rdata (arr_rdata)
	);

	obcl_mode_select u_mode (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.word_valid      (boot_done_r),
		.special_word    (special_config_readback_r),
		.strap_phase     (strap_phase),
		.strap_polarity  (strap_polarity),
		.serial_phase    (serial_phase),
		.serial_polarity (serial_polarity)
	);

endmodule : obcl_loader

// file: obcl_loader_props.sv
// Checker for the loader's bus handshake and load timing.
// Assumes it is bound to obcl_loader and sees only its ports.
`timescale 1ns/1ps
module obcl_loader_props
	import obcl_pkg::*;
(
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic                   hready,
	input wire logic [31:0]            hrdata,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic                   wakeup,
	input wire logic [OBCL_UID_W-1:0]  unique_identifier,
	input wire logic [OBCL_TUNE_W-1:0] regulator_tune_register
);
	logic       taken;
	logic [3:0] cyc_r;
	logic [4:0] wake_age_r;

	assign taken = hsel && htrans[1] && hready;

	// Cycles since reset release, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cyc_r <= 4'h0;
		else if (cyc_r != 4'hF)
			cyc_r <= cyc_r + 4'h1;
	end

	// Cycles since the last wakeup, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wake_age_r <= 5'h1F;
		else if (wakeup)
			wake_age_r <= 5'h00;
		else if (wake_age_r != 5'h1F)
			wake_age_r <= wake_age_r + 5'h01;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("Response other than OKAY");
	a_take_stalls: assert property (taken |=> !hreadyout)
		else $error("No wait state after a taken transfer");
	a_stall_cause: assert property ($fell(hreadyout) |-> $past(taken))
		else $error("Wait state without a transfer");
	a_wait_bounded: assert property (!hreadyout |-> ##[1:24] hreadyout)
		else $error("Transfer never completed");
	a_data_at_done: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("Read data moved outside completion");
	a_unmapped_zero: assert property (taken && !hwrite && haddr > 32'h0000_0028
		|-> first_match(##[2:24] hreadyout) ##0 hrdata == 32'h0000_0000)
		else $error("Unmapped read not zero");
	a_boot_stall: assert property (taken && cyc_r == 4'h0 |=> !hreadyout [*2])
		else $error("Bus answered during boot load");
	a_uid_boot_only: assert property ($changed(unique_identifier) |-> cyc_r < 4'h6)
		else $error("Identifier changed outside boot load");
	a_tune_on_wake: assert property ($changed(regulator_tune_register) |->
		wake_age_r < 5'h14)
		else $error("Tuning changed without wakeup");
endmodule : obcl_loader_props

bind obcl_loader obcl_loader_props props_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .hreadyout, .hresp, .wakeup, .unique_identifier,
	.regulator_tune_register);

// file: obcl_host_model.sv
// Host side model: single-word AHB-Lite master with register sequences.
// Assumes one slave, so hready is the slave's hreadyout.
`timescale 1ns/1ps
module obcl_host_model
	import obcl_pkg::*;
(
	input  wire logic        hclk,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	int          gap = 0;
	logic [31:0] dummy;

	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end

	// Released address and data lines show inverted values so stale data never looks valid
	task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd_data);
		repeat (gap) @(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= is_wr;
		hsize <= 3'h2;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~{24'h00_0000, a};
		hwdata <= is_wr ? d : ~hwdata;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		rd_data = hrdata;
		hwdata <= ~d;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, dummy);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h0000_0000, d);
	endtask : rd

	task automatic word_read(input logic [10:0] wa, output logic [31:0] d);
		wr(OBCL_REG_ADDR, {21'h0, wa});
		wr(OBCL_REG_CTRL, {24'h0, OBCL_CMD_READ});
		rd(OBCL_REG_RDATA, d);
	endtask : word_read

	task automatic word_prog(input logic [10:0] wa, input logic [31:0] d);
		wr(OBCL_REG_WDATA, d);
		wr(OBCL_REG_ADDR, {21'h0, wa});
		wr(OBCL_REG_CTRL, {24'h0, OBCL_CMD_PROG});
	endtask : word_prog
endmodule : obcl_host_model

// file: obcl_loader_test.sv
// Self-checking bench for the boot configuration loader.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module obcl_loader_test
	import obcl_pkg::*;
;
	logic                   hclk = 1'b0;
	logic                   hresetn;
	logic                   por_n;
	logic                   wakeup;
	logic                   strap_phase;
	logic                   strap_polarity;
	wire logic              hsel, hwrite, hreadyout, hresp;
	wire logic [31:0]       haddr, hwdata, hrdata;
	wire logic [1:0]        htrans;
	wire logic [2:0]        hsize;
	wire logic              serial_phase, serial_polarity;
	wire logic [63:0]       unique_identifier;
	wire logic [39:0]       regulator_tune_register;
	int                     failures = 0;
	int                     checks_done = 0;
	integer                 seed = 32'hA0C4F311;
	logic [31:0]            w [6];
	logic [31:0]            d, d2, sw;

	always #12.5 hclk = ~hclk;

	obcl_host_model host_u (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata);
	obcl_loader dut_u (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .wakeup, .strap_phase,
		.strap_polarity, .serial_phase, .serial_polarity, .unique_identifier,
		.regulator_tune_register);

	// --------------------------------
	// Expectations and checking
	// --------------------------------
	function automatic logic [39:0] exp_tune(input logic [31:0] lo, input logic [31:0] hi);
		return {hi[7:0], lo};
	endfunction : exp_tune

	function automatic logic [1:0] exp_mode(input logic [31:0] s, input logic ph, input logic pl);
		return (s[4:3] == OBCL_OVR_EN_ON) ? s[1:0] : {ph, pl};
	endfunction : exp_mode

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chk_mode(input logic [31:0] s, input string what);
		chk(64'({serial_phase, serial_polarity}),
			64'(exp_mode(s, strap_phase, strap_polarity)), what);
	endtask : chk_mode

	task automatic do_reset(input int n);
		hresetn <= 1'b0;
		repeat (n) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : do_reset

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		hresetn = 1'b0;
		por_n = 1'b0;
		wakeup = 1'b0;
		strap_phase = 1'($random(seed));
		strap_polarity = 1'($random(seed));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		host_u.rd(OBCL_REG_UID_LO, d);
		chk(64'(d), 64'h0, "erased identifier");
		host_u.wr(OBCL_REG_SPECIAL, 32'hFFFF_FFFF);
		host_u.rd(OBCL_REG_SPECIAL, d);
		chk(64'(d), 64'h0, "erased special word");
		chk_mode(32'h0, "strap mode");
		host_u.rd(OBCL_REG_CFG, d);
		chk(64'(d), 64'h1, "config reset value");
		host_u.rd(OBCL_REG_STATUS, d);
		chk(64'(d), 64'h1, "boot done status");
		host_u.wr(8'h3C, 32'hFFFF_FFFF);
		host_u.rd(8'h3C, d);
		chk(64'(d), 64'h0, "unmapped read");
		for (int i = 0; i < 6; i++) begin
			w[i] = $random(seed);
			host_u.gap = i % 3;
			host_u.word_prog(11'(i), w[i]);
		end
		for (int i = 0; i < 6; i++) begin
			host_u.word_read(11'(i), d);
			chk(64'(d), 64'(w[i]), "array word");
		end
		host_u.rd(OBCL_REG_ADDR, d);
		chk(64'(d), 64'h5, "word address readback");
		host_u.gap = 0;
		wakeup <= 1'b1;
		@(posedge hclk);
		wakeup <= 1'b0;
		host_u.rd(OBCL_REG_TUNE_LO, d);
		host_u.rd(OBCL_REG_TUNE_HI, d2);
		chk(64'({d2[7:0], d}), 64'(exp_tune(w[4], w[5])), "tuning regs");
		chk(64'(regulator_tune_register), 64'(exp_tune(w[4], w[5])), "tuning port");
		sw = {27'h0, 2'b01, 1'b0, ~strap_phase, ~strap_polarity};
		host_u.word_prog(OBCL_SPECIAL_ADDR, sw);
		host_u.rd(OBCL_REG_SPECIAL, d);
		chk(64'(d), 64'(sw), "programmed special word");
		do_reset(3);
		host_u.rd(OBCL_REG_UID_LO, d);
		host_u.rd(OBCL_REG_UID_HI, d2);
		chk({d2, d}, {w[1], w[0]}, "identifier registers");
		chk(unique_identifier, {w[1], w[0]}, "identifier port");
		chk_mode(sw, "override mode");
		// Field becomes 11, which must fall back to the straps
		host_u.word_prog(OBCL_SPECIAL_ADDR, 32'h0000_0010);
		sw = sw | 32'h0000_0010;
		do_reset(2);
		host_u.rd(OBCL_REG_SPECIAL, d);
		chk(64'(d), 64'(sw), "special word after reset");
		@(posedge hclk);
		chk_mode(sw, "disabled override");
		host_u.wr(OBCL_REG_CFG, 32'h0000_0000);
		wakeup <= 1'b1;
		@(posedge hclk);
		wakeup <= 1'b0;
		repeat (8) @(posedge hclk);
		chk(64'(regulator_tune_register), 64'h0, "wakeup copy disabled");
		host_u.rd(OBCL_REG_STATUS, d);
		chk(64'(d), 64'h1, "no wakeup pending");
		print_verdict();
	end

	// Run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule : obcl_loader_test
